// *** core/vef_cfg.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef VEF_CFG_SVH
`define VEF_CFG_SVH

`define VEF_OFF_CTRL 8'h00
`define VEF_OFF_COLOR 8'h04
`define VEF_OFF_STATUS 8'h08
`define VEF_OFF_LINE 8'h0C

`define VEF_CTRL_HD 0
`define VEF_CTRL_FMT422 1
`define VEF_CTRL_RGB 2
`define VEF_CTRL_ASYNC 3
`define VEF_CTRL_EMB 4
`define VEF_CTRL_LIM_EN 5
`define VEF_CTRL_LIM_LO 6
`define VEF_CTRL_LIM_HI 7
`define VEF_CTRL_PAT_EN 8
`define VEF_CTRL_PAT_FIELD 9
`define VEF_CTRL_RESET 10'h000
`define VEF_COLOR_RESET 30'h3FFAAEB0

`define VEF_ST_STRAP 0
`define VEF_ST_OVF 1
`define VEF_ST_ACTIVE 2

`define VEF_BLACK_Y 10'h040
`define VEF_BLACK_C 10'h200
`define VEF_LIM_FLOOR_1P5 10'h033
`define VEF_LIM_FLOOR_6 10'h00B
`define VEF_LIM_FLOOR_11 10'h000

`define VEF_EMB_PREAMBLE_HI 10'h3FF
`define VEF_EMB_PREAMBLE_LO 10'h000
`define VEF_EMB_BIT_V 7
`define VEF_EMB_BIT_H 6
`define VEF_HSYNC_LEN 8'h2C
`define VEF_HATCH_SHIFT 5
`define VEF_STRAP_WAIT 2'h3

`endif

// *** core/vef_pkg.sv ***
// types shared by the pixel front end
package vef_pkg;
   typedef enum logic [1:0] {
      LIM_1P5,
      LIM_6,
      LIM_11,
      LIM_OFF
   } vef_lim_t;

   typedef enum {
      EMB_IDLE,
      EMB_HI,
      EMB_LO1,
      EMB_LO2
   } vef_emb_state_t;
endpackage

// *** core/vef_sync2.sv ***
// two flop synchroniser for pin inputs
`timescale 1ns/100ps
module vef_sync2 #(
   parameter int W = 1
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised copy
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// *** core/vef_fifo.sv ***
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module vef_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid, // not empty
   input wire logic out_ready, // read request
   output logic [WIDTH-1:0] out_data, // head word
   output logic [$clog2(DEPTH):0] level // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;

   assign in_ready = count_reg < (AW+1)'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;

   always_ff @(posedge pclk) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_wr && !do_rd) count_reg <= count_reg + 1'b1;
         else if (do_rd && !do_wr) count_reg <= count_reg - 1'b1;
      end
   end
endmodule

// *** core/vef_top.sv ***
// pixel front end: capture, timing decode, pattern, limiter, dac feed
//
// Contract
// - the control port address low bit is taken from the strap pin.
// - the shared pin is a clock output in progressive mode only.
// - the red chroma port carries Cr or red, ignored in 4:2:2.
// - reset clears the timing generator and every register; the colour register loads 30'h3FFAAEB0 instead.
// - horizontal input is hsync, or composite sync in async mode.
// - vertical input is vsync, or tri-level control in async mode.
// - a whole pixel word is captured at each pixel clock rise.
// - sync insertion follows external pulses or embedded codes.
// - luma feeds converter A, chroma paths feed B and C.
// - progressive only luma limiter clamps at -1.5, -6 or -11 IRE.
// - the pattern generator makes a cross hatch over black.
// - it also makes a uniform field; the colour is programmable.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "vef_cfg.svh"
module vef_top #(
   parameter int FIFO_DEPTH = 16,
   parameter int HATCH_SHIFT = `VEF_HATCH_SHIFT
) (
   input wire logic pclk, // bus and pixel logic clock
   input wire logic presetn, // async reset, active low
   input wire logic [7:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic ref_pixel_clock, // pixel clock from source
   input wire logic [9:0] luma_port, // luma or green
   input wire logic [9:0] red_chroma_port, // Cr or red
   input wire logic [9:0] mux_chroma_port, // Cb/Cr or blue
   input wire logic horiz_timing_n, // hsync or composite sync
   input wire logic vert_timing_n, // vsync or tri-level control
   input wire logic blanking_ctrl_in, // active video when high
   output logic pixel_clock_out, // clock out on shared pin
   output logic pixel_clock_out_oe, // shared pin driven when high
   input wire logic address_low_bit_pin, // address strap
   output logic ctrl_addr_lsb, // strapped address bit
   input wire logic dac_ready, // converters take a sample
   output logic dac_valid, // sample on dac outputs
   output logic [9:0] dac_a, // luma converter
   output logic [9:0] dac_b, // red chroma converter
   output logic [9:0] dac_c, // shared chroma converter
   output logic dac_sync, // sync insertion
   output logic dac_trilevel, // tri-level sync insertion
   output logic dac_blank // blanking
);
   import vef_pkg::*;

   localparam int FW = 33;

   // pin synchronisers, all pins in one group so they stay aligned
   logic [34:0] pin_sync;
   vef_sync2 #(.W(35)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({ref_pixel_clock, luma_port, red_chroma_port, mux_chroma_port,
          horiz_timing_n, vert_timing_n, blanking_ctrl_in,
          address_low_bit_pin}),
      .q(pin_sync)
   );
   wire s_clk = pin_sync[34];
   wire [9:0] s_y = pin_sync[33:24];
   wire [9:0] s_r = pin_sync[23:14];
   wire [9:0] s_m = pin_sync[13:4];
   wire s_h_n = pin_sync[3];
   wire s_v_n = pin_sync[2];
   wire s_dv = pin_sync[1];
   wire s_strap = pin_sync[0];

   // registers
   logic [9:0] ctrl_reg;
   logic [29:0] color_reg;
   logic ovf_reg;
   logic strap_reg;
   logic [1:0] strap_cnt_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;

   wire hd_mode = ctrl_reg[`VEF_CTRL_HD];
   wire fmt422 = ctrl_reg[`VEF_CTRL_FMT422];
   wire rgb_in = ctrl_reg[`VEF_CTRL_RGB];
   wire async_mode = ctrl_reg[`VEF_CTRL_ASYNC];
   wire emb_mode = ctrl_reg[`VEF_CTRL_EMB];
   wire lim_en = ctrl_reg[`VEF_CTRL_LIM_EN];
   wire [1:0] lim_sel = ctrl_reg[`VEF_CTRL_LIM_HI:`VEF_CTRL_LIM_LO];
   wire pat_en = ctrl_reg[`VEF_CTRL_PAT_EN];
   wire pat_field = ctrl_reg[`VEF_CTRL_PAT_FIELD];
   wire [9:0] col_y = color_reg[9:0];
   wire [9:0] col_cb = color_reg[19:10];
   wire [9:0] col_cr = color_reg[29:20];

   // pixel clock edge: the clock rides the same synchroniser as data
   logic clk_prev_reg;
   wire pix_tick = s_clk && !clk_prev_reg;

   // embedded code detection
   vef_emb_state_t emb_state_reg;
   vef_emb_state_t emb_state_next;
   logic emb_h_reg;
   logic emb_v_reg;
   logic [7:0] emb_sync_cnt_reg;
   wire emb_code = (emb_state_reg == EMB_LO2);
   wire emb_eav = emb_code && s_y[`VEF_EMB_BIT_H];

   always_comb begin
      emb_state_next = emb_state_reg;
      unique case (emb_state_reg)
         EMB_IDLE:
            if (s_y == `VEF_EMB_PREAMBLE_HI) emb_state_next = EMB_HI;
         EMB_HI:
            emb_state_next = (s_y == `VEF_EMB_PREAMBLE_LO) ? EMB_LO1 :
                             (s_y == `VEF_EMB_PREAMBLE_HI) ? EMB_HI :
                             EMB_IDLE;
         EMB_LO1:
            emb_state_next = (s_y == `VEF_EMB_PREAMBLE_LO) ? EMB_LO2 :
                             EMB_IDLE;
         EMB_LO2:
            emb_state_next = EMB_IDLE;
      endcase
   end

   // timing decode
   wire ext_hsync = !s_h_n;
   wire ext_vsync = !s_v_n && !async_mode;
   wire trilevel_timing_in = !s_v_n && async_mode;
   // the shared pin is an output in progressive mode, so blanking then
   // comes from the sync pulses alone
   wire ext_active = hd_mode ? s_dv : !(ext_hsync || ext_vsync);
   wire emb_active = !emb_h_reg && !emb_v_reg;
   wire active_now = (emb_mode && !async_mode) ? emb_active :
                     ext_active;
   wire sync_now = (emb_mode && !async_mode) ?
                   (emb_sync_cnt_reg != 8'h00) : ext_hsync;
   wire vert_now = (emb_mode && !async_mode) ? emb_v_reg : ext_vsync;

   logic act_prev_reg;
   logic sync_prev_reg;
   logic vert_prev_reg;
   logic phase_reg;
   logic [11:0] hcnt_reg;
   logic [11:0] lcnt_reg;
   logic [9:0] cb_hold_reg;
   logic [9:0] cr_hold_reg;
   wire act_start = active_now && !act_prev_reg;
   wire line_start = sync_now && !sync_prev_reg;
   wire frame_start = vert_now && !vert_prev_reg;
   // chroma phase restarts at each active start: even pixels carry Cb
   wire cb_slot = act_start || !phase_reg;

   // capture stage, held while the fifo is full until the next pixel tick overwrites it
   logic cap_valid_reg;
   logic [9:0] cap_y_reg;
   logic [9:0] cap_cr_reg;
   logic [9:0] cap_cb_reg;
   logic cap_sync_reg;
   logic cap_tri_reg;
   logic cap_blank_reg;
   logic cap_hatch_reg;

   wire [9:0] cap_cr_next = !fmt422 ? s_r :
                            cb_slot ? cr_hold_reg : s_m;
   wire [9:0] cap_cb_next = (!fmt422 || cb_slot) ? s_m : cb_hold_reg;
   wire [HATCH_SHIFT-1:0] hmod = hcnt_reg[HATCH_SHIFT-1:0];
   wire [HATCH_SHIFT-1:0] lmod = lcnt_reg[HATCH_SHIFT-1:0];
   wire hatch_next = (hmod == '0) || (lmod == '0);

   // pattern, blanking and limiter on the captured word
   wire pat_line = pat_field || cap_hatch_reg;
   wire [9:0] pat_y = pat_line ? col_y : `VEF_BLACK_Y;
   wire [9:0] pat_cb = pat_line ? col_cb : `VEF_BLACK_C;
   wire [9:0] pat_cr = pat_line ? col_cr : `VEF_BLACK_C;
   // rgb input blanks all three channels to the black code
   wire [9:0] blank_c = rgb_in ? `VEF_BLACK_Y : `VEF_BLACK_C;
   wire [9:0] src_y = cap_blank_reg ? `VEF_BLACK_Y :
                      pat_en ? pat_y : cap_y_reg;
   wire [9:0] src_cr = cap_blank_reg ? blank_c :
                       pat_en ? pat_cr : cap_cr_reg;
   wire [9:0] src_cb = cap_blank_reg ? blank_c :
                       pat_en ? pat_cb : cap_cb_reg;
   wire [9:0] lim_floor = (lim_sel == LIM_1P5) ? `VEF_LIM_FLOOR_1P5 :
                          (lim_sel == LIM_6) ? `VEF_LIM_FLOOR_6 :
                          `VEF_LIM_FLOOR_11;
   wire lim_on = lim_en && !hd_mode && (lim_sel != LIM_OFF);
   wire [9:0] lim_y = (lim_on && src_y < lim_floor) ? lim_floor :
                      src_y;

   // fifo between capture and converters
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [FW-1:0] fifo_out_data;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;
   wire fifo_out_ready = !dac_valid || dac_ready;
   wire cap_take = cap_valid_reg && fifo_in_ready;
   // a tick that lands on an unaccepted word overwrites it
   wire ovf_set = pix_tick && cap_valid_reg && !fifo_in_ready;

   vef_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(cap_valid_reg),
      .in_ready(fifo_in_ready),
      .in_data({cap_sync_reg, cap_tri_reg, cap_blank_reg,
                lim_y, src_cr, src_cb}),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // apb decode
   wire apb_setup = psel && !penable;
   wire apb_wr = psel && penable && pready_reg && pwrite;
   wire hit_ctrl = paddr == `VEF_OFF_CTRL;
   wire hit_color = paddr == `VEF_OFF_COLOR;
   wire hit_status = paddr == `VEF_OFF_STATUS;
   wire hit_line = paddr == `VEF_OFF_LINE;
   wire hit_any = hit_ctrl || hit_color || hit_status || hit_line;
   wire [31:0] status_word = {11'h000, 5'(fifo_level), 13'h0000,
                              active_now, ovf_reg, strap_reg};
   wire [31:0] rd_word = hit_ctrl ? {22'h000000, ctrl_reg} :
                         hit_color ? {2'h0, color_reg} :
                         hit_status ? status_word :
                         hit_line ? {20'h00000, lcnt_reg} : 32'h00000000;
   wire ovf_clr = apb_wr && hit_status && pwdata[`VEF_ST_OVF];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `VEF_CTRL_RESET;
         color_reg <= `VEF_COLOR_RESET;
         ovf_reg <= 1'b0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup && !hit_any;
         if (apb_setup) prdata_reg <= pwrite ? 32'h00000000 : rd_word;
         if (apb_wr && hit_ctrl) ctrl_reg <= pwdata[9:0];
         if (apb_wr && hit_color) color_reg <= pwdata[29:0];
         // hardware set wins over a same cycle clear
         ovf_reg <= ovf_set || (ovf_reg && !ovf_clr);
      end
   end

   // strap caught once the synchroniser holds a settled value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_cnt_reg <= 2'h0;
         strap_reg <= 1'b0;
      end else if (strap_cnt_reg != `VEF_STRAP_WAIT) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == `VEF_STRAP_WAIT - 2'h1) begin
            strap_reg <= s_strap;
         end
      end
   end

   // timing generator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_reg <= 1'b0;
         emb_state_reg <= EMB_IDLE;
         emb_h_reg <= 1'b1;
         emb_v_reg <= 1'b1;
         emb_sync_cnt_reg <= 8'h00;
         act_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         vert_prev_reg <= 1'b0;
         phase_reg <= 1'b0;
         hcnt_reg <= 12'h000;
         lcnt_reg <= 12'h000;
         cb_hold_reg <= `VEF_BLACK_C;
         cr_hold_reg <= `VEF_BLACK_C;
      end else begin
         clk_prev_reg <= s_clk;
         if (pix_tick) begin
            emb_state_reg <= emb_state_next;
            if (emb_code) begin
               emb_h_reg <= s_y[`VEF_EMB_BIT_H];
               emb_v_reg <= s_y[`VEF_EMB_BIT_V];
            end
            if (emb_eav) emb_sync_cnt_reg <= `VEF_HSYNC_LEN;
            else if (emb_sync_cnt_reg != 8'h00)
               emb_sync_cnt_reg <= emb_sync_cnt_reg - 8'h01;
            act_prev_reg <= active_now;
            sync_prev_reg <= sync_now;
            vert_prev_reg <= vert_now;
            phase_reg <= active_now ? cb_slot : 1'b0;
            hcnt_reg <= act_start ? 12'h001 : hcnt_reg + 12'h001;
            if (frame_start) lcnt_reg <= 12'h000;
            else if (line_start) lcnt_reg <= lcnt_reg + 12'h001;
            if (cb_slot) cb_hold_reg <= s_m;
            else cr_hold_reg <= s_m;
         end
      end
   end

   // capture stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_valid_reg <= 1'b0;
         cap_y_reg <= `VEF_BLACK_Y;
         cap_cr_reg <= `VEF_BLACK_C;
         cap_cb_reg <= `VEF_BLACK_C;
         cap_sync_reg <= 1'b0;
         cap_tri_reg <= 1'b0;
         cap_blank_reg <= 1'b1;
         cap_hatch_reg <= 1'b0;
      end else if (pix_tick) begin
         cap_valid_reg <= 1'b1;
         cap_y_reg <= s_y;
         cap_cr_reg <= cap_cr_next;
         cap_cb_reg <= cap_cb_next;
         cap_sync_reg <= sync_now;
         cap_tri_reg <= trilevel_timing_in;
         cap_blank_reg <= !active_now;
         cap_hatch_reg <= act_start || hatch_next;
      end else if (cap_take) begin
         cap_valid_reg <= 1'b0;
      end
   end

   // converter outputs and shared clock pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_valid <= 1'b0;
         dac_a <= `VEF_BLACK_Y;
         dac_b <= `VEF_BLACK_C;
         dac_c <= `VEF_BLACK_C;
         dac_sync <= 1'b0;
         dac_trilevel <= 1'b0;
         dac_blank <= 1'b1;
         pixel_clock_out <= 1'b0;
         pixel_clock_out_oe <= 1'b0;
      end else begin
         if (fifo_out_ready) begin
            dac_valid <= fifo_out_valid;
            if (fifo_out_valid) begin
               dac_sync <= fifo_out_data[32];
               dac_trilevel <= fifo_out_data[31];
               dac_blank <= fifo_out_data[30];
               dac_a <= fifo_out_data[29:20];
               dac_b <= fifo_out_data[19:10];
               dac_c <= fifo_out_data[9:0];
            end
         end
         // divided from pclk so the pin never sees a glitch
         pixel_clock_out_oe <= !hd_mode;
         pixel_clock_out <= !hd_mode && !pixel_clock_out;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign ctrl_addr_lsb = strap_reg;
endmodule

// *** bench/vef_top_props.sv ***
// port checker for the pixel front end
`timescale 1ns/100ps
module vef_top_props (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic pixel_clock_out, // shared pin clock
   input wire logic pixel_clock_out_oe, // shared pin enable
   input wire logic address_low_bit_pin, // strap pin
   input wire logic ctrl_addr_lsb, // strap caught
   input wire logic dac_ready, // converter accepts
   input wire logic dac_valid, // sample present
   input wire logic [9:0] dac_a, // luma converter
   input wire logic [9:0] dac_b, // red chroma converter
   input wire logic dac_blank // blanking
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_stall;
      dac_valid && !dac_ready;
   endsequence
   AST_STRAP: assert property (presetn[*4] |-> ctrl_addr_lsb == address_low_bit_pin)
      else $error("strap bit differs from pin");
   AST_CLK_TOGGLE: assert property (pixel_clock_out_oe[*2] |-> pixel_clock_out != $past(pixel_clock_out))
      else $error("shared pin clock not toggling");
   AST_CLK_IDLE: assert property (!pixel_clock_out_oe[*2] |-> !pixel_clock_out)
      else $error("clock on shared pin while released");
   AST_RESET_OUT: assert property ($rose(presetn) |-> !dac_valid && !pready && dac_blank && dac_a == 10'h040 && dac_b == 10'h200)
      else $error("outputs not at reset values");
   AST_APB_ANSWER: assert property (s_setup |=> pready)
      else $error("no ready in access cycle");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_APB_ERR: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_VALID_HELD: assert property (s_stall |=> dac_valid)
      else $error("sample dropped while stalled");
   AST_DATA_HELD: assert property (s_stall |=> $stable(dac_a) && $stable(dac_b))
      else $error("sample changed while stalled");
endmodule

bind vef_top vef_top_props i_vef_top_props (.pclk, .presetn, .psel, .penable,
   .pready, .pslverr, .pixel_clock_out, .pixel_clock_out_oe,
   .address_low_bit_pin, .ctrl_addr_lsb, .dac_ready, .dac_valid, .dac_a,
   .dac_b, .dac_blank);

// *** bench/vef_src_model.sv ***
// upstream video source: pixel clock, pixel words, sync levels
`timescale 1ns/100ps
module vef_src_model (
   input wire logic pclk, // bench clock
   input wire logic presetn, // reset, active low
   input wire logic go, // send pixels while high
   input wire logic hs_set, // horizontal timing level
   input wire logic vs_set, // vertical timing level
   output logic ref_pixel_clock, // pixel clock, still when idle
   output logic [9:0] luma_port, // luma or green
   output logic [9:0] red_chroma_port, // Cr or red
   output logic [9:0] mux_chroma_port, // Cb/Cr or blue
   output logic horiz_timing_n, // horizontal timing
   output logic vert_timing_n, // vertical timing
   output logic blank_drv // active video on shared pin
);
   logic [1:0] ph;
   logic [7:0] k;
   // scaled clock: four bench clocks a pixel suits the two flop sampler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 2'h0;
         k <= 8'h00;
         ref_pixel_clock <= 1'b0;
      end else if (go || ph != 2'h0) begin
         ph <= ph + 2'h1;
         ref_pixel_clock <= ph == 2'h1 || ph == 2'h2;
         if (ph == 2'h3)
            k <= k + 8'h01;
      end
   end
   // data moves at the fall, two bench clocks clear of the rise
   assign luma_port = {2'b00, k};
   assign red_chroma_port = {2'b01, k};
   assign mux_chroma_port = {2'b10, k};
   assign horiz_timing_n = hs_set;
   assign vert_timing_n = vs_set;
   assign blank_drv = 1'b1;
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the pixel front end
`timescale 1ns/100ps
module testbench;
   logic pclk, presetn, pwrite, pready, pslverr, ref_clk, hs_n, vs_n;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic blank_drv, blank_wire, lsb, clk_out, clk_oe, dac_valid;
   logic dsync, dtri, dblank;
   logic [9:0] luma, red, mux, dac_a, dac_b, dac_c;
   logic strap = 1'b0;
   logic dac_ready = 1'b1;
   logic go = 1'b0;
   logic hs_set = 1'b1;
   logic vs_set = 1'b1;
   logic prev_ok = 1'b0;
   logic [7:0] last = 8'h00;
   logic [29:0] col = 30'h0;
   int num_errors = 0;
   int check_count = 0;
   int mmode = 0;
   int cycles = 0;
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // level on the shared pin from both drivers
   assign blank_wire = clk_oe ? clk_out : blank_drv;
   vef_top i_vef_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_pixel_clock(ref_clk), .luma_port(luma), .red_chroma_port(red),
      .mux_chroma_port(mux), .horiz_timing_n(hs_n), .vert_timing_n(vs_n),
      .blanking_ctrl_in(blank_wire), .pixel_clock_out(clk_out),
      .pixel_clock_out_oe(clk_oe), .address_low_bit_pin(strap),
      .ctrl_addr_lsb(lsb), .dac_ready(dac_ready), .dac_valid(dac_valid),
      .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_sync(dsync),
      .dac_trilevel(dtri), .dac_blank(dblank));
   vef_src_model i_vef_src_model (.pclk(pclk), .presetn(presetn), .go(go),
      .hs_set(hs_set), .vs_set(vs_set), .ref_pixel_clock(ref_clk),
      .luma_port(luma), .red_chroma_port(red), .mux_chroma_port(mux),
      .horiz_timing_n(hs_n), .vert_timing_n(vs_n), .blank_drv(blank_drv));
   task automatic wrap_up();
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic bad(input string msg);
      num_errors++;
      $display("BAD t=%0t %s", $time, msg);
   endtask
   task automatic sig_chk(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) bad(msg);
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      if (n == 50) bad("no apb ready");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] exp, input logic exp_err, input string msg);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check_count++;
      if ((rd & m) !== exp || err !== exp_err) bad(msg);
   endtask
   function automatic logic sample_ok();
      logic blk, fld;
      blk = dac_a === 10'h040 && dac_b === 10'h200 && dac_c === 10'h200;
      fld = dac_a === col[9:0] && dac_b === col[29:20]
         && dac_c === col[19:10];
      case (mmode)
         1: return dblank === 1'b0 && dac_b[9:8] === 2'b01
            && dac_c === {2'b10, dac_b[7:0]} && dac_a === (dac_b[7:0] < 8'h33
            ? 10'h033 : {2'b00, dac_b[7:0]})
            && (!prev_ok || dac_b[7:0] === last + 8'h01);
         2: return dblank === 1'b0 && dac_a[9:8] === 2'b00
            && dac_b[9:8] === 2'b10 && dac_c[9:8] === 2'b10;
         3: return dblank === 1'b0 && fld;
         4: return dblank === 1'b0 && (blk || fld);
         default: return dsync === !hs_set && dtri === !vs_set;
      endcase
   endfunction
   always @(negedge pclk) begin
      if (mmode != 0 && dac_valid === 1'b1 && dac_ready === 1'b1) begin
         check_count++;
         if (!sample_ok()) bad("converter sample");
         last = dac_b[7:0];
         prev_ok = 1'b1;
      end
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         bad("timeout");
         wrap_up();
      end
   end
   task automatic run_mode(input logic [31:0] ctrl, input int m);
      int n0;
      wr(8'h00, ctrl);
      go <= 1'b1;
      repeat (60) @(posedge pclk);
      prev_ok = 1'b0;
      n0 = check_count;
      mmode = m;
      repeat (400) @(posedge pclk);
      mmode = 0;
      go <= 1'b0;
      if (check_count - n0 < 50) bad("too few samples");
   endtask
   task automatic t_reset(input logic pin);
      presetn <= 1'b0;
      strap <= pin;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_chk(8'h00, 32'hFFFFFFFF, 32'h0, 1'b0, "ctrl default");
      rd_chk(8'h04, 32'hFFFFFFFF, 32'h3FFAAEB0, 1'b0, "color default");
      rd_chk(8'h08, 32'h1, {31'h0, pin}, 1'b0, "strap status");
      rd_chk(8'h10, 32'hFFFFFFFF, 32'h0, 1'b1, "unmapped read");
      sig_chk(lsb, pin, "strap bit");
      sig_chk(clk_oe, 1'b1, "shared pin not driven");
   endtask
   task automatic t_regs();
      wr(8'h00, 32'hFFFFFFFF);
      rd_chk(8'h00, 32'hFFFFFFFF, 32'h3FF, 1'b0, "ctrl width");
      sig_chk(clk_oe, 1'b0, "shared pin driven in hd");
      t_reset(1'b1);
   endtask
   task automatic t_field();
      col = {10'h2A5, 10'h15A, 10'h0C3};
      wr(8'h04, {2'b00, col});
      run_mode(32'h301, 3);
      run_mode(32'h101, 4);
   endtask
   task automatic t_async();
      hs_set <= 1'b0;
      run_mode(32'h9, 5);
      hs_set <= 1'b1;
      vs_set <= 1'b0;
      run_mode(32'h9, 5);
      vs_set <= 1'b1;
   endtask
   task automatic t_overflow();
      wr(8'h00, 32'h1);
      dac_ready <= 1'b0;
      go <= 1'b1;
      repeat (160) @(posedge pclk);
      go <= 1'b0;
      repeat (8) @(posedge pclk);
      rd_chk(8'h08, 32'h1F0002, 32'h100002, 1'b0, "full, overflow");
      wr(8'h08, 32'h2);
      rd_chk(8'h08, 32'h2, 32'h0, 1'b0, "overflow not cleared");
      dac_ready <= 1'b1;
      repeat (60) @(posedge pclk);
      rd_chk(8'h08, 32'h1F0000, 32'h0, 1'b0, "fifo not drained");
   endtask
   initial begin
      presetn = 1'b0;
      pwrite = 1'b0;
      @(posedge pclk);
      t_reset(1'b0);
      t_regs();
      run_mode(32'h20, 1);
      run_mode(32'h3, 2);
      t_field();
      t_async();
      t_overflow();
      wrap_up();
   end
endmodule
